// file: pkg/eir_pkg.sv
// Shared constants and types for the external interrupt recognition block
package eir_pkg;
	localparam int EIR_PINS = 3;
	localparam int EIR_LEVELS = 7;
	// Debounce span in periods; a filtered level needs three equal samples in a row
	localparam int EIR_HOLD_CLKS = 2;
	// Level mapping of the individual request inputs
	localparam logic [2:0] EIR_IND_LVL0 = 3'h1;
	localparam logic [2:0] EIR_IND_LVL1 = 3'h4;
	localparam logic [2:0] EIR_IND_LVL2 = 3'h7;
	localparam logic [2:0] EIR_NO_LEVEL = 3'h0;
	// Acknowledge cycle address fields
	localparam logic [22:0] EIR_ACK_ADDR_HI = 23'h7fffff;
	localparam logic [1:0] EIR_ACK_ADDR_LO = 2'h0;
	localparam logic [1:0] EIR_TKIND_ACK = 2'h3;
	localparam logic [1:0] EIR_TKIND_IDLE = 2'h0;
	// Internal vector base for autovectored levels
	localparam logic [7:0] EIR_AUTOVEC_BASE = 8'h18;
	localparam logic [27:0] EIR_ADDR_RST = 28'h0000000;
	localparam logic [7:0] EIR_VEC_RST = 8'h00;
	typedef enum logic [2:0] {
		EIR_IDLE,
		EIR_ACK_START,
		EIR_ACK_WAIT,
		EIR_HANDLER
	} eir_state_t;
endpackage

// file: pkg/eir_filt_if.sv
// Carrier for filtered pin levels between the filter and the controller
`timescale 1ns/10ps
interface eir_filt_if;
	logic [eir_pkg::EIR_PINS:0] level;
	modport src (output level);
	modport dst (input level);
endinterface

// file: rtl/eir_filter.sv
// Per-pin synchroniser and two-period debounce filter
`timescale 1ns/10ps
module eir_filter
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [eir_pkg::EIR_PINS:0] i_raw,
	eir_filt_if.src filt
);
	import eir_pkg::*;

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g <= EIR_PINS; g++)
		begin : g_pin
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic held_r;
			logic out_r;
			wire logic agree = (s2_r == s3_r);
			// Pins idle high (inactive), so reset to one
			always_ff @(posedge i_clock or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					s1_r <= 1'b1;
					s2_r <= 1'b1;
					s3_r <= 1'b1;
					held_r <= 1'b1;
					out_r <= 1'b1;
				end
				else
				begin
					s1_r <= i_raw[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					held_r <= s3_r;
					// Accept only a value stable over two periods; glitches die here
					if (agree && (s3_r == held_r))
						out_r <= s3_r;
				end
			end
			assign filt.level[g] = out_r;
		end
	endgenerate
endmodule

// file: rtl/eir_top.sv
// External interrupt recognition: masking, priority, exception take, acknowledge
`timescale 1ns/10ps
module eir_top
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [eir_pkg::EIR_PINS-1:0] i_external_request_inputs_n,
	input wire logic i_encoded_mode,
	input wire logic [eir_pkg::EIR_LEVELS:1] i_level_mask,
	input wire logic [eir_pkg::EIR_LEVELS:1] i_autovector_select,
	input wire logic [2:0] i_core_mask,
	input wire logic i_insn_boundary,
	input wire logic i_higher_exc_pending,
	input wire logic i_insn_done,
	input wire logic i_sync_transfer_done_n,
	input wire logic i_async_transfer_done_n,
	input wire logic [7:0] i_data_hi,
	output logic [2:0] o_presented_level,
	output logic o_pending,
	output logic o_take,
	output logic o_bus_active,
	output logic o_ts_n,
	output logic o_read,
	output logic [1:0] o_transfer_kind,
	output logic [27:0] o_addr,
	output logic [7:0] o_vector,
	output logic o_vector_valid,
	output logic [2:0] o_ack_level
);
	import eir_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin filtering; async done shares the same synchroniser path
	eir_filt_if filt ();

	eir_filter u_filter
	(
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_raw({i_async_transfer_done_n, i_external_request_inputs_n}),
		.filt(filt.src)
	);

	wire logic [EIR_PINS-1:0] pins_n = filt.level[EIR_PINS-1:0];
	wire logic async_done = ~filt.level[EIR_PINS];

	////////////////////////////////////////////////////////////////////////
	// Request decode: individual pins or one encoded level
	logic [EIR_LEVELS:1] req;
	wire logic [2:0] enc_level = ~pins_n;

	always_comb
	begin
		req = '0;
		if (i_encoded_mode)
		begin
			if (enc_level != EIR_NO_LEVEL)
				req[enc_level] = 1'b1;
		end
		else
		begin
			req[EIR_IND_LVL0] = ~pins_n[0];
			req[EIR_IND_LVL1] = ~pins_n[1];
			req[EIR_IND_LVL2] = ~pins_n[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// First masking stage and priority pick; zero when nothing left
	wire logic [EIR_LEVELS:1] unmasked = req & ~i_level_mask;
	logic [2:0] best_level;

	always_comb
	begin
		best_level = EIR_NO_LEVEL;
		for (int l = 1; l <= EIR_LEVELS; l++)
		begin
			if (unmasked[l])
				best_level = 3'(l);
		end
	end

	// Core mask is the highest ignored level
	wire logic core_pending = (o_presented_level > i_core_mask);

	////////////////////////////////////////////////////////////////////////
	// Exception sequencing and acknowledge cycle
	eir_state_t state_r;
	eir_state_t state_nxt;
	logic [2:0] lvl_r;
	wire logic take_now = (state_r == EIR_IDLE) && o_pending && i_insn_boundary
		&& !i_higher_exc_pending;
	wire logic use_auto = i_autovector_select[o_presented_level];
	wire logic bus_done = !i_sync_transfer_done_n || async_done;
	wire logic [27:0] ack_addr = {EIR_ACK_ADDR_HI, o_presented_level, EIR_ACK_ADDR_LO};
	wire logic [7:0] auto_vec = EIR_AUTOVEC_BASE + {5'h00, o_presented_level};

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			EIR_IDLE:
			begin
				if (take_now)
					state_nxt = use_auto ? EIR_HANDLER : EIR_ACK_START;
			end
			EIR_ACK_START:
				state_nxt = EIR_ACK_WAIT;
			EIR_ACK_WAIT:
			begin
				if (bus_done)
					state_nxt = EIR_HANDLER;
			end
			EIR_HANDLER:
			begin
				// Blocks recognition until a handler instruction retires
				if (i_insn_done)
					state_nxt = EIR_IDLE;
			end
			default:
				state_nxt = EIR_IDLE;
		endcase
	end

	// Presented level and pending flag
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_presented_level <= EIR_NO_LEVEL;
			o_pending <= 1'b0;
		end
		else
		begin
			o_presented_level <= best_level;
			o_pending <= core_pending && (state_nxt == EIR_IDLE);
		end
	end

	// State and captured level
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state_r <= EIR_IDLE;
			lvl_r <= EIR_NO_LEVEL;
		end
		else
		begin
			state_r <= state_nxt;
			if (take_now)
				lvl_r <= o_presented_level;
		end
	end

	// Bus outputs for the acknowledge read
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_bus_active <= 1'b0;
			o_ts_n <= 1'b1;
			o_read <= 1'b1;
			o_transfer_kind <= EIR_TKIND_IDLE;
			o_addr <= EIR_ADDR_RST;
		end
		else
		begin
			o_ts_n <= !(take_now && !use_auto);
			if (take_now && !use_auto)
			begin
				o_bus_active <= 1'b1;
				o_read <= 1'b1;
				o_transfer_kind <= EIR_TKIND_ACK;
				o_addr <= ack_addr;
			end
			else if (state_r == EIR_ACK_WAIT && bus_done)
			begin
				o_bus_active <= 1'b0;
				o_transfer_kind <= EIR_TKIND_IDLE;
				o_addr <= EIR_ADDR_RST;
			end
		end
	end

	// Vector capture: internal or from the top data byte
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_take <= 1'b0;
			o_vector <= EIR_VEC_RST;
			o_vector_valid <= 1'b0;
			o_ack_level <= EIR_NO_LEVEL;
		end
		else
		begin
			o_take <= take_now;
			o_vector_valid <= 1'b0;
			if (take_now && use_auto)
			begin
				o_vector <= auto_vec;
				o_vector_valid <= 1'b1;
				o_ack_level <= o_presented_level;
			end
			else if (state_r == EIR_ACK_WAIT && bus_done)
			begin
				o_vector <= i_data_hi;
				o_vector_valid <= 1'b1;
				o_ack_level <= lvl_r;
			end
		end
	end
endmodule

// file: bench/eir_assertions.sv
// Port checker for the interrupt recognition block
`timescale 1ns/10ps
module eir_assertions
(
	input wire logic i_clock, i_rstn, i_insn_boundary, i_higher_exc_pending,
	input wire logic o_pending, o_take, o_bus_active, o_ts_n, o_read, o_vector_valid,
	input wire logic [2:0] i_core_mask, o_presented_level, o_ack_level,
	input wire logic [1:0] o_transfer_kind,
	input wire logic [27:0] o_addr,
	input wire logic [7:0] o_vector
);
import eir_pkg::*;
default clocking @(posedge i_clock); endclocking
default disable iff (!i_rstn);
chk_pend_above_mask: assert property (o_pending |-> $past(o_presented_level) > $past(i_core_mask))
	else $error("pending not above core mask");
chk_zero_no_pend: assert property (o_presented_level == 3'h0 |=> !o_pending)
	else $error("pending with no level");
chk_take_cause: assert property (o_take |-> $past(o_pending) && $past(i_insn_boundary)
	&& !$past(i_higher_exc_pending)) else $error("take without cause");
chk_one_take: assert property (o_take |=> !o_take && !o_pending)
	else $error("take repeated");
chk_bus_no_pend: assert property (o_bus_active |-> !o_pending)
	else $error("pending during ack");
chk_start_pulse: assert property (!o_ts_n |-> o_transfer_kind == EIR_TKIND_ACK ##1 o_ts_n)
	else $error("bad start pulse");
chk_ack_addr: assert property (o_bus_active |-> o_read && o_addr[27:5] == EIR_ACK_ADDR_HI
	&& o_addr[1:0] == EIR_ACK_ADDR_LO) else $error("bad ack address");
// Level field follows the level presented when the take happened
chk_ack_level: assert property (!o_ts_n |-> o_addr[4:2] == $past(o_presented_level))
	else $error("bad ack level");
chk_vec_level: assert property (o_vector_valid && $past(o_bus_active)
	|-> o_ack_level == $past(o_addr[4:2])) else $error("ack level lost");
chk_idle_bus: assert property (!o_bus_active |-> o_transfer_kind == EIR_TKIND_IDLE)
	else $error("kind outside ack");
chk_auto_vector: assert property (o_vector_valid && !$past(o_bus_active)
	|-> o_vector == EIR_AUTOVEC_BASE + o_ack_level) else $error("bad autovector");
endmodule
bind eir_top eir_assertions u_eir_assertions (.*);

// file: bench/eir_periph.sv
// Peripheral model: requests held until acknowledged, answers ack reads
`timescale 1ns/10ps
module eir_periph
(
	input wire logic clk, enc, slow, ts_n, busy, vld,
	input wire logic [2:0] lvl, g,
	output logic [2:0] pins_n = 3'h7,
	output logic ta_n = 1'b1, at_n = 1'b1,
	output logic [7:0] d = 8'h00
);
logic [2:0] hold = 3'h0;
// Slow mode answers on the async pin; bus shows inverse when idle
always @(posedge clk)
begin
	hold <= vld ? 3'h0 : (lvl != 3'h0 ? lvl : hold);
	pins_n <= ~((enc ? hold : {hold == 3'h7, hold == 3'h4, hold == 3'h1}) | g);
	ta_n <= ts_n || slow;
	at_n <= !(busy && ts_n && slow);
	d <= busy ? {5'h08, hold} : ~{5'h08, hold};
end
endmodule

// file: bench/test_eir_top.sv
// Directed bench for the interrupt recognition block
`timescale 1ns/10ps
module test_eir_top;
logic i_clock = 0, i_rstn = 0, enc = 0, slow = 0, bnd = 0, hx = 0, idn = 0;
logic [7:1] msk = 0, av = 0;
logic [2:0] cm = 0, lvl = 0, g = 0, pins, pl, al;
logic ta_n, at_n, pd, tk, ba, ts, rd, vv;
logic [7:0] d, vec;
logic [1:0] tkd;
logic [27:0] ad;
int fail_count = 0, cmp_count = 0, tks = 0;
always #4 i_clock = ~i_clock;
always @(negedge i_clock) if (tk === 1'b1) tks++;
eir_top u_eir_top(.i_clock(i_clock), .i_rstn(i_rstn), .i_external_request_inputs_n(pins),
	.i_encoded_mode(enc), .i_level_mask(msk), .i_autovector_select(av), .i_core_mask(cm),
	.i_insn_boundary(bnd), .i_higher_exc_pending(hx), .i_insn_done(idn),
	.i_sync_transfer_done_n(ta_n), .i_async_transfer_done_n(at_n), .i_data_hi(d),
	.o_presented_level(pl), .o_pending(pd), .o_take(tk), .o_bus_active(ba), .o_ts_n(ts),
	.o_read(rd), .o_transfer_kind(tkd), .o_addr(ad), .o_vector(vec), .o_vector_valid(vv),
	.o_ack_level(al));
eir_periph u_eir_periph(.clk(i_clock), .enc(enc), .slow(slow), .ts_n(ts), .busy(ba),
	.vld(vv), .lvl(lvl), .g(g), .pins_n(pins), .ta_n(ta_n), .at_n(at_n), .d(d));
task chk(input logic [31:0] s, e);
	cmp_count++;
	if (s !== e)
	begin
		fail_count++;
		$display("MISMATCH t=%0t seen %h want %h", $time, s, e);
	end
endtask
task w(input int k);
	repeat (k) @(negedge i_clock);
endtask
task done;
	@(posedge i_clock) idn <= 1;
	@(posedge i_clock) idn <= 0;
	// Released pins need the filter latency before the next request
	repeat (10) @(posedge i_clock);
endtask
// Request a level, take it, check the ack cycle and vector
task run(input logic [2:0] l, input logic [7:0] v, input logic a);
	int n;
	n = 0;
	@(posedge i_clock) lvl <= l;
	av[l] <= a;
	bnd <= 1;
	hx <= 0;
	@(posedge i_clock) lvl <= 0;
	// Sample at the falling edge only; a deferred take may already be in flight
	do
	begin
		w(1);
		n++;
		if (ts === 1'b0) chk(ad, {23'h7fffff, l, 2'h0});
		if (a) chk(ba, 1'b0);
	end while (vv !== 1'b1 && n < 99);
	chk(vec, v);
	chk(al, l);
	@(posedge i_clock) bnd <= 0;
endtask
task finish_test;
	$display("compares %0d mismatches %0d", cmp_count, fail_count);
	if (fail_count == 0 && cmp_count > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
initial
begin
	#20000;
	fail_count++;
	finish_test;
end
initial
begin
	repeat (2) @(posedge i_clock);
	i_rstn <= 1;
	run(3'h4, 8'h1c, 1);
	@(posedge i_clock) lvl <= 4;
	@(posedge i_clock) lvl <= 0;
	w(12);
	chk(pd, 1'b0);
	done;
	w(3);
	chk(pd, 1'b1);
	@(posedge i_clock) hx <= 1;
	bnd <= 1;
	w(8);
	chk(tks, 1);
	run(3'h4, 8'h1c, 1);
	done;
	@(posedge i_clock) enc <= 1;
	run(3'h5, 8'h45, 0);
	done;
	@(posedge i_clock) enc <= 0;
	slow <= 1;
	run(3'h7, 8'h47, 0);
	done;
	@(posedge i_clock) g <= 3'h4;
	@(posedge i_clock) g <= 3'h0;
	// Watch every cycle; an accepted glitch would show only briefly
	repeat (10)
	begin
		w(1);
		chk(pl, 3'h0);
	end
	@(posedge i_clock) msk[1] <= 1;
	lvl <= 1;
	@(posedge i_clock) lvl <= 0;
	w(10);
	chk(pl, 3'h0);
	@(posedge i_clock) msk[1] <= 0;
	cm <= 1;
	w(3);
	chk(pl, 3'h1);
	chk(pd, 1'b0);
	@(posedge i_clock) cm <= 0;
	w(3);
	chk(pd, 1'b1);
	finish_test;
end
endmodule
